// file: pkg/tcio_pkg.sv
package tcio_pkg;
  localparam int unsigned NCH = 6;
  localparam int unsigned AW  = 5;
  localparam int unsigned DW  = 16;

  // Register map, word addresses on the plain register port
  localparam logic [4:0] ADDR_IRQ_EN0 = 5'h00;
  localparam logic [4:0] ADDR_IO_CH4  = 5'h06;
  localparam logic [4:0] ADDR_IO_CH5  = 5'h07;
  localparam logic [4:0] ADDR_STAT0   = 5'h08;
  localparam logic [4:0] ADDR_CH3_MODE = 5'h0e;
  localparam logic [4:0] ADDR_GRA4    = 5'h10;
  localparam logic [4:0] ADDR_GRA5    = 5'h11;
  localparam logic [4:0] ADDR_CNT4    = 5'h12;
  localparam logic [4:0] ADDR_CNT5    = 5'h13;
  localparam logic [4:0] ADDR_CNT_EN  = 5'h14;

  // Enable register bit positions
  localparam int unsigned EN_ADC = 7;
  localparam int unsigned EN_RSV = 6;
  localparam int unsigned EN_UNF = 5;
  localparam int unsigned EN_OVF = 4;
  localparam int unsigned EN_D   = 3;
  localparam int unsigned EN_C   = 2;
  localparam int unsigned EN_B   = 1;
  localparam int unsigned EN_A   = 0;

  // Status register bit position (same as enables for flags) and channel 3 buffer mode bit
  localparam int unsigned ST_DIR = 7;
  localparam int unsigned BFA_BIT = 0;

  localparam logic [7:0] IRQ_EN_RST  = 8'h40;
  localparam logic [7:0] STAT_RST    = 8'hc0;
  // Writable enable bits: channels 0/3 versus 1/2/4/5
  localparam logic [7:0] EN_MASK_CD  = 8'h9f;
  localparam logic [7:0] EN_MASK_UNF = 8'hb3;
  localparam logic [7:0] ST_MASK_CD  = 8'h1f;
  localparam logic [7:0] ST_MASK_UNF = 8'h33;
  localparam logic [3:0] IO_RST      = 4'h0;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [15:0] CNT_RST    = 16'h0000;
  localparam logic [15:0] GRA_RST    = 16'hffff;
endpackage

// file: pkg/tcio_ch_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tcio_ch_if;
  logic [3:0]  io_sel;
  logic        io_ld;
  logic        gra_wr;
  logic [15:0] wdata;
  logic        cnt_en;
  logic        pin_in;
  logic        ext_src;
  logic [15:0] gra;
  logic [15:0] cnt;
  logic        evt_a;
  logic        ovf;
  logic        pin_out;
  logic        pin_oe_n;

  modport ctl (output io_sel, io_ld, gra_wr, wdata, cnt_en, pin_in, ext_src,
               input gra, cnt, evt_a, ovf, pin_out, pin_oe_n);
  modport unit (input io_sel, io_ld, gra_wr, wdata, cnt_en, pin_in, ext_src,
                output gra, cnt, evt_a, ovf, pin_out, pin_oe_n);
endinterface
`default_nettype wire

// file: logic/tcio_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tcio_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Level
  input  wire logic d,
  output var  logic q
);
  logic meta;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// file: logic/tcio_capcmp.sv
`timescale 1ns/1ps
`default_nettype none
module tcio_capcmp #(
  parameter bit EXT_SRC = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Channel link to the register side
  tcio_ch_if.unit  u
);
  import tcio_pkg::*;

  logic [15:0] next_cnt;
  logic        pin_q;
  logic        rise;
  logic        fall;
  logic        src_hit;
  logic        capture;
  logic        match;

  always_comb begin
    next_cnt = u.cnt + 16'h0001;
    rise     = u.pin_in & ~pin_q;
    fall     = ~u.pin_in & pin_q;
    if (EXT_SRC && u.io_sel[3:2] == 2'b11) begin
      src_hit = u.ext_src;                    // [RL9]
    end else if (u.io_sel[1]) begin
      src_hit = rise | fall;                  // [RL8]
    end else if (u.io_sel[0]) begin
      src_hit = fall;                         // [RL7]
    end else begin
      src_hit = rise;                         // [RL6]
    end
    // Without the external source option bit 2 never matters
    capture = u.io_sel[3] & src_hit;          // [RL10]
    match   = ~u.io_sel[3] & u.cnt_en & (next_cnt == u.gra);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= u.pin_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      u.cnt <= CNT_RST;
      u.ovf <= 1'b0;
    end else begin
      u.ovf <= u.cnt_en & (u.cnt == CNT_MAX); // [RL21]
      if (u.cnt_en) begin
        u.cnt <= next_cnt;
      end
    end
  end

  // Capture beats a software write in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      u.gra <= GRA_RST;
    end else if (capture) begin
      u.gra <= u.cnt;                         // [RL6]
    end else if (u.gra_wr) begin
      u.gra <= u.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      u.evt_a <= 1'b0;
    end else begin
      u.evt_a <= capture | match;             // [RL20]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      u.pin_out <= 1'b0;
    end else if (u.io_ld) begin
      // Level comes from the code being written, not the old one
      u.pin_out <= u.wdata[2];                // [RL5]
    end else if (match) begin
      case (u.io_sel[1:0])
        2'b01:   u.pin_out <= 1'b0;           // [RL2]
        2'b10:   u.pin_out <= 1'b1;           // [RL3]
        2'b11:   u.pin_out <= ~u.pin_out;     // [RL4]
        default: u.pin_out <= u.pin_out;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      u.pin_oe_n <= 1'b1;
    end else begin
      u.pin_oe_n <= u.io_sel[3] | (u.io_sel[1:0] == 2'b00); // [RL23]
    end
  end
endmodule
`default_nettype wire

// file: logic/tcio_top.sv
// What this block does
// RL1 - Channel 3 buffer mode A set: register C makes no capture or compare events.
// RL2 - Compare mode, low bits 01: pin goes low on each match.
// RL3 - Compare mode, low bits 10: pin goes high on each match.
// RL4 - Compare mode, low bits 11: pin toggles on each match.
// RL5 - Top select bit 0 means compare; bit 2 sets initial pin level.
// RL6 - Capture mode, low bits 00: capture counter on rising edge.
// RL7 - Capture mode, low bits 01: capture counter on falling edge.
// RL8 - Capture mode, bit 1 set: capture counter on both edges.
// RL9 - Channel 4, top bits 11: capture on channel 3 register A event.
// RL10 - Channel 5 capture ignores bit 2 and always uses its own pin.
// RL11 - Six 8-bit enable registers, 0x40 after reset or standby.
// RL12 - Enable bit 7 lets register A events request A/D conversion start.
// RL13 - Enable bit 6 ignores writes and reads as one.
// RL14 - Bit 5 gates underflow request; reads zero, unwritable in channels 0 and 3.
// RL15 - Bit 4 gates the overflow request.
// RL16 - Bit 3 gates register D request; bits 3,2 zero in channels 1,2,4,5.
// RL17 - Bit 2 gates the register C request in channels 0 and 3.
// RL18 - Bit 1 gates the register B request.
// RL19 - Bit 0 gates the register A request.
// RL20 - Match flag sets on compare equality or on a capture.
// RL21 - Overflow flag sets when the counter wraps from FFFF to 0000.
// RL22 - Each request is high while its flag and enable are both one; the code registers it, so it follows one cycle later.
// RL23 - Compare codes 0000 and 0100 leave the pin output disabled.
`timescale 1ns/1ps
`default_nettype none
module tcio_top (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   hw_stby,
  // Register port
  input  wire logic [tcio_pkg::AW-1:0] addr,
  input  wire logic [tcio_pkg::DW-1:0] wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output var  logic [tcio_pkg::DW-1:0] rdata,
  // Events from the counter core of channels 0 to 3 and up/down logic
  input  wire logic [5:0]             ext_evt_a,
  input  wire logic [5:0]             ext_evt_b,
  input  wire logic [5:0]             ext_evt_c,
  input  wire logic [5:0]             ext_evt_d,
  input  wire logic [5:0]             ext_ovf,
  input  wire logic [5:0]             ext_unf,
  // Timer pins, channels 4 and 5
  input  wire logic                   ch4_pin_a_in,
  output var  logic                   ch4_pin_a_out,
  output var  logic                   ch4_pin_a_oe_n,
  input  wire logic                   ch5_pin_a_in,
  output var  logic                   ch5_pin_a_out,
  output var  logic                   ch5_pin_a_oe_n,
  // Requests to the interrupt controller and A/D converter
  output var  logic [5:0]             match_irq_a,
  output var  logic [5:0]             match_irq_b,
  output var  logic [5:0]             match_irq_c,
  output var  logic [5:0]             match_irq_d,
  output var  logic [5:0]             overflow_irq,
  output var  logic [5:0]             underflow_irq,
  output var  logic [5:0]             adc_trigger
);
  import tcio_pkg::*;

  tcio_ch_if c4 ();
  tcio_ch_if c5 ();

  logic [7:0]  irq_enable_reg [NCH];
  logic [7:0]  status_reg     [NCH];
  logic [3:0]  io_ch4;
  logic [3:0]  io_ch5;
  logic        buffer_mode_a;
  logic [1:0]  cnt_run;
  logic [5:0]  evt_a;
  logic [5:0]  evt_c;
  logic [5:0]  ovf;
  logic [7:0]  set_bits [NCH];
  logic [15:0] next_rdata;
  logic        ch4_pin_s;
  logic        ch5_pin_s;

  function automatic logic has_cd(input int unsigned ch);
    has_cd = (ch == 0) || (ch == 3);
  endfunction

  function automatic logic [7:0] en_mask(input int unsigned ch);
    en_mask = has_cd(ch) ? EN_MASK_CD : EN_MASK_UNF;
  endfunction

  function automatic logic [7:0] st_mask(input int unsigned ch);
    st_mask = has_cd(ch) ? ST_MASK_CD : ST_MASK_UNF;
  endfunction

  function automatic logic hit(input logic [AW-1:0] base, input int unsigned ch);
    hit = (addr == base + AW'(ch));
  endfunction

  // A request is its flag gated by the enable bit at the same position
  function automatic logic req(input logic [7:0] st, input logic [7:0] en,
                               input int unsigned b);
    req = st[b] & en[b];
  endfunction

  // Pins come from outside the clock domain
  tcio_sync u_sync4 (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (ch4_pin_a_in),
    .q     (ch4_pin_s)
  );

  tcio_sync u_sync5 (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (ch5_pin_a_in),
    .q     (ch5_pin_s)
  );

  assign c4.io_sel  = io_ch4;
  assign c4.io_ld   = wr && addr == ADDR_IO_CH4;
  assign c4.gra_wr  = wr && addr == ADDR_GRA4;
  assign c4.wdata   = wdata;
  assign c4.cnt_en  = cnt_run[0];
  assign c4.pin_in  = ch4_pin_s;
  assign c4.ext_src = ext_evt_a[3];           // [RL9]

  assign c5.io_sel  = io_ch5;
  assign c5.io_ld   = wr && addr == ADDR_IO_CH5;
  assign c5.gra_wr  = wr && addr == ADDR_GRA5;
  assign c5.wdata   = wdata;
  assign c5.cnt_en  = cnt_run[1];
  assign c5.pin_in  = ch5_pin_s;
  assign c5.ext_src = 1'b0;

  tcio_capcmp #(.EXT_SRC(1'b1)) u_ch4 (
    .clk   (clk),
    .rst_n (rst_n),
    .u     (c4)
  );

  tcio_capcmp #(.EXT_SRC(1'b0)) u_ch5 (
    .clk   (clk),
    .rst_n (rst_n),
    .u     (c5)
  );

  assign ch4_pin_a_out  = c4.pin_out;
  assign ch4_pin_a_oe_n = c4.pin_oe_n;
  assign ch5_pin_a_out  = c5.pin_out;
  assign ch5_pin_a_oe_n = c5.pin_oe_n;

  // Channels 4 and 5 use the local capture/compare units
  always_comb begin
    evt_a = {c5.evt_a, c4.evt_a, ext_evt_a[3:0]};
    ovf   = {c5.ovf, c4.ovf, ext_ovf[3:0]};
    evt_c = ext_evt_c;
    evt_c[3] = ext_evt_c[3] & ~buffer_mode_a; // [RL1]
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      set_bits[i] = 8'h00;
      set_bits[i][EN_A]   = evt_a[i];         // [RL20]
      set_bits[i][EN_B]   = ext_evt_b[i];
      set_bits[i][EN_C]   = evt_c[i];
      set_bits[i][EN_D]   = ext_evt_d[i];
      set_bits[i][EN_OVF] = ovf[i];           // [RL21]
      set_bits[i][EN_UNF] = ext_unf[i];
      set_bits[i] = set_bits[i] & st_mask(i);
    end
  end

  // Select codes; the pin level is loaded by the unit at the same edge
  always_ff @(posedge clk) begin
    if (!rst_n || hw_stby) begin
      io_ch4 <= IO_RST;
    end else if (wr && addr == ADDR_IO_CH4) begin
      io_ch4 <= wdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || hw_stby) begin
      io_ch5 <= IO_RST;
    end else if (wr && addr == ADDR_IO_CH5) begin
      io_ch5 <= wdata[3:0];
    end
  end

  // Buffer mode silences register C events of channel 3
  always_ff @(posedge clk) begin
    if (!rst_n || hw_stby) begin
      buffer_mode_a <= 1'b0;
    end else if (wr && addr == ADDR_CH3_MODE) begin
      buffer_mode_a <= wdata[BFA_BIT];
    end
  end

  // Counters stop in standby so software restarts them explicitly
  always_ff @(posedge clk) begin
    if (!rst_n || hw_stby) begin
      cnt_run <= 2'b00;
    end else if (wr && addr == ADDR_CNT_EN) begin
      cnt_run <= wdata[1:0];
    end
  end

  // Enable registers; fixed bits come from the mask
  always_ff @(posedge clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (!rst_n || hw_stby) begin
        irq_enable_reg[i] <= IRQ_EN_RST;      // [RL11]
      end else if (wr && hit(ADDR_IRQ_EN0, i)) begin
        irq_enable_reg[i] <= (wdata[7:0] & en_mask(i)) | IRQ_EN_RST; // [RL13] [RL14] [RL16]
      end
    end
  end

  // Flags clear by writing zero; a set in the same cycle wins
  always_ff @(posedge clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (!rst_n || hw_stby) begin
        status_reg[i] <= STAT_RST;
      end else if (wr && hit(ADDR_STAT0, i)) begin
        status_reg[i] <= (status_reg[i] & (wdata[7:0] | ~st_mask(i))) | set_bits[i];
      end else begin
        status_reg[i] <= status_reg[i] | set_bits[i];
      end
    end
  end

  // Registered requests lag the flag by one cycle, keeping outputs glitch free
  always_ff @(posedge clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (!rst_n || hw_stby) begin
        match_irq_a[i] <= 1'b0;
      end else begin
        match_irq_a[i] <= req(status_reg[i], irq_enable_reg[i], EN_A); // [RL19] [RL22]
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (!rst_n || hw_stby) begin
        match_irq_b[i] <= 1'b0;
      end else begin
        match_irq_b[i] <= req(status_reg[i], irq_enable_reg[i], EN_B); // [RL18] [RL22]
      end
    end
  end

  // Flags C and D exist only in channels 0 and 3; the masks keep others low
  always_ff @(posedge clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (!rst_n || hw_stby) begin
        match_irq_c[i] <= 1'b0;
      end else begin
        match_irq_c[i] <= req(status_reg[i], irq_enable_reg[i], EN_C); // [RL17] [RL22]
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (!rst_n || hw_stby) begin
        match_irq_d[i] <= 1'b0;
      end else begin
        match_irq_d[i] <= req(status_reg[i], irq_enable_reg[i], EN_D); // [RL16] [RL22]
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (!rst_n || hw_stby) begin
        overflow_irq[i] <= 1'b0;
      end else begin
        overflow_irq[i] <= req(status_reg[i], irq_enable_reg[i], EN_OVF); // [RL15] [RL22]
      end
    end
  end

  // Underflow exists only in channels 1, 2, 4 and 5
  always_ff @(posedge clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (!rst_n || hw_stby) begin
        underflow_irq[i] <= 1'b0;
      end else begin
        underflow_irq[i] <= req(status_reg[i], irq_enable_reg[i], EN_UNF); // [RL14] [RL22]
      end
    end
  end

  // A/D start is a one-cycle pulse per register A event
  always_ff @(posedge clk) begin
    if (!rst_n || hw_stby) begin
      adc_trigger <= 6'h00;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        adc_trigger[i] <= evt_a[i] & irq_enable_reg[i][EN_ADC]; // [RL12]
      end
    end
  end

  always_comb begin
    next_rdata = 16'h0000;
    for (int i = 0; i < NCH; i++) begin
      if (hit(ADDR_IRQ_EN0, i)) begin
        next_rdata = {8'h00, irq_enable_reg[i]};
      end
      if (hit(ADDR_STAT0, i)) begin
        next_rdata = {8'h00, status_reg[i]};
      end
    end
    case (addr)
      ADDR_IO_CH4:   next_rdata = {12'h000, io_ch4};
      ADDR_IO_CH5:   next_rdata = {12'h000, io_ch5};
      ADDR_CH3_MODE: next_rdata = {15'h0000, buffer_mode_a};
      ADDR_GRA4:     next_rdata = c4.gra;
      ADDR_GRA5:     next_rdata = c5.gra;
      ADDR_CNT4:     next_rdata = c4.cnt;
      ADDR_CNT5:     next_rdata = c5.cnt;
      ADDR_CNT_EN:   next_rdata = {14'h0000, cnt_run};
      default:       next_rdata = next_rdata;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// file: dv/tcio_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tcio_assertions (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        hw_stby,
  // Register port
  input wire logic [4:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  // Events, pin and requests
  input wire logic [5:0]  ext_evt_a,
  input wire logic        ch4_pin_a_out,
  input wire logic        ch4_pin_a_oe_n,
  input wire logic [5:0]  match_irq_a,
  input wire logic [5:0]  overflow_irq,
  input wire logic [5:0]  adc_trigger
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_wr_en0; wr && addr == 5'h00; endsequence
  sequence s_rd_en0; rd && addr == 5'h00; endsequence
  sequence s_io4_wr; wr && addr == 5'h06; endsequence

  a_rsv_reads_one: assert property ($past(rd) && $past(addr) < 5'h06 |-> rdata[6] == 1'b1)
    else $error("enable bit 6 read as zero");
  a_unf_reads_zero: assert property ($past(rd) && ($past(addr) == 5'h00 ||
    $past(addr) == 5'h03) |-> rdata[5] == 1'b0)
    else $error("underflow enable readable in channel 0 or 3");
  a_cd_reads_zero: assert property ($past(rd) && $past(addr) inside {5'h01, 5'h02, 5'h04,
    5'h05} |-> rdata[3:2] == 2'b00)
    else $error("enable bits 3 and 2 not zero");
  a_adc_follows_evt: assert property (adc_trigger[3:0] != 4'h0 |->
    (adc_trigger[3:0] & ~$past(ext_evt_a[3:0])) == 4'h0)
    else $error("conversion start without register A event");
  a_stby_clears_req: assert property (hw_stby |-> ##2 (match_irq_a == 6'h00 &&
    overflow_irq == 6'h00 && adc_trigger == 6'h00))
    else $error("requests survive standby");
  a_off_code_float: assert property (s_io4_wr ##0 (wdata[3:0] == 4'h0 || wdata[3:0] == 4'h4)
    |-> ##2 ch4_pin_a_oe_n == 1'b1)
    else $error("pin driven with output disabled code");
  a_init_level: assert property (s_io4_wr ##0 (!wdata[3] && wdata[1:0] != 2'b00)
    |=> ch4_pin_a_out == $past(wdata[2]))
    else $error("initial pin level wrong");
  a_en_readback: assert property (s_wr_en0 ##1 !wr ##1 s_rd_en0
    |=> rdata[7:0] == (($past(wdata[7:0], 3) & 8'h9f) | 8'h40))
    else $error("enable register read back wrong");
endmodule
`default_nettype wire

// file: dv/tcio_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcio_pin_model (
  // Timer side
  input  wire logic out,
  input  wire logic oe_n,
  // Test side level when released
  input  wire logic lvl,
  output var  logic pin
);
  // Driven pin reads back its own level
  always_comb begin
    pin = oe_n ? lvl : out;
  end
endmodule
`default_nettype wire

// file: dv/tcio_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tcio_top_tb;
  import tcio_pkg::*;
  localparam logic [3:0] CMP_CODE [4] = '{4'h5, 4'h2, 4'h7, 4'h3};
  localparam logic [3:0] CAP_CODE [4] = '{4'h8, 4'h9, 4'ha, 4'hc};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hw_stby = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic [4:0]  sa;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        lvl = 1'b0;
  logic [15:0] rdata, c;
  logic [5:0]  ev [6];
  logic        ch4_pin_a_in, ch4_pin_a_out, ch4_pin_a_oe_n;
  logic        ch5_pin_a_in, ch5_pin_a_out, ch5_pin_a_oe_n;
  logic [5:0]  match_irq_a, match_irq_b, match_irq_c, match_irq_d;
  logic [5:0]  overflow_irq, underflow_irq, adc_trigger;
  int          err_total = 0;
  int          n_checks = 0;
  int          cyc = 0;

  always #12.5 clk = ~clk;

  tcio_top DUT (.clk, .rst_n, .hw_stby, .addr, .wdata, .wr, .rd, .rdata,
    .ext_evt_a(ev[0]), .ext_evt_b(ev[1]), .ext_evt_c(ev[2]), .ext_evt_d(ev[3]),
    .ext_ovf(ev[4]), .ext_unf(ev[5]), .ch4_pin_a_in, .ch4_pin_a_out, .ch4_pin_a_oe_n,
    .ch5_pin_a_in, .ch5_pin_a_out, .ch5_pin_a_oe_n, .match_irq_a, .match_irq_b,
    .match_irq_c, .match_irq_d, .overflow_irq, .underflow_irq, .adc_trigger);
  tcio_pin_model u_pin4 (.out(ch4_pin_a_out), .oe_n(ch4_pin_a_oe_n), .lvl(lvl),
    .pin(ch4_pin_a_in));
  tcio_pin_model u_pin5 (.out(ch5_pin_a_out), .oe_n(ch5_pin_a_oe_n), .lvl(lvl),
    .pin(ch5_pin_a_in));

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Tasks start and end at a rising edge; one idle cycle keeps strobes single
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd_reg(a, d);
    chk(d, e);
  endtask

  // One-cycle pulse on every event kind of the masked channels
  task automatic pulse(input logic [5:0] m);
    foreach (ev[j]) ev[j] <= m;
    @(posedge clk);
    foreach (ev[j]) ev[j] <= 6'h00;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    foreach (ev[j]) ev[j] = 6'h00;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      rd_chk(5'(i), 16'h0040);
      wr_reg(5'(i), 16'hffff);
      rd_chk(5'(i), (i == 0 || i == 3) ? 16'h00df : 16'h00f3);
    end
    pulse(6'h3f);
    @(negedge clk);
    chk(16'(adc_trigger), 16'h000f);
    @(posedge clk);
    @(negedge clk);
    chk(16'(match_irq_a), 16'h000f);
    chk(16'(match_irq_b), 16'h003f);
    chk(16'(match_irq_c), 16'h0009);
    chk(16'(match_irq_d), 16'h0009);
    chk(16'(overflow_irq), 16'h000f);
    chk(16'(underflow_irq), 16'h0036);
    @(posedge clk);
    rd_chk(ADDR_STAT0, 16'h00df);
    rd_chk(ADDR_STAT0 + 5'h01, 16'h00f3);
    wr_reg(ADDR_IRQ_EN0, 16'h0000);
    wr_reg(ADDR_STAT0 + 5'h01, 16'h0000);
    @(negedge clk);
    chk(16'(match_irq_a), 16'h000c);
    chk(16'(overflow_irq), 16'h000c);
    @(posedge clk);
    wr_reg(ADDR_CH3_MODE, 16'h0001);
    wr_reg(ADDR_STAT0 + 5'h03, 16'h0000);
    pulse(6'h08);
    rd_chk(ADDR_STAT0 + 5'h03, 16'h00db);
    chk(16'(match_irq_c), 16'h0000);
    wr_reg(ADDR_CH3_MODE, 16'h0000);
    hw_stby <= 1'b1;
    @(posedge clk);
    hw_stby <= 1'b0;
    @(posedge clk);
    rd_chk(ADDR_IRQ_EN0 + 5'h01, 16'h0040);
    wr_reg(ADDR_IRQ_EN0 + 5'h04, 16'h0081);
    foreach (CMP_CODE[i]) begin
      wr_reg(ADDR_CNT_EN, 16'h0000);
      rd_reg(ADDR_CNT4, c);
      wr_reg(ADDR_GRA4, c + 16'h0008);
      wr_reg(ADDR_IO_CH4, 16'(CMP_CODE[i]));
      @(negedge clk);
      chk(16'({ch4_pin_a_oe_n, ch4_pin_a_out}), 16'(4'h5 >> i) & 16'h0001);
      @(posedge clk);
      wr_reg(ADDR_CNT_EN, 16'h0001);
      repeat (12) @(posedge clk);
      @(negedge clk);
      chk(16'(ch4_pin_a_out), 16'(4'ha >> i) & 16'h0001);
      chk(16'(match_irq_a[4]), 16'h0001);
      @(posedge clk);
      wr_reg(ADDR_STAT0 + 5'h04, 16'h0000);
    end
    wr_reg(ADDR_IO_CH4, 16'h0004);
    @(negedge clk);
    chk(16'(ch4_pin_a_oe_n), 16'h0001);
    @(posedge clk);
    wr_reg(ADDR_CNT_EN, 16'h0000);
    foreach (CAP_CODE[i]) begin
      sa = ADDR_STAT0 + ((4'h9 >> i) & 4'h1 ? 5'h05 : 5'h04);
      wr_reg(sa - 5'h06, 16'(CAP_CODE[i]));
      wr_reg(sa, 16'h0000);
      lvl <= 1'b1;
      repeat (6) @(posedge clk);
      rd_chk(sa, 16'h00c0 | (16'(4'hd >> i) & 16'h0001));
      wr_reg(sa, 16'h0000);
      lvl <= 1'b0;
      repeat (6) @(posedge clk);
      rd_chk(sa, 16'h00c0 | (16'(4'h6 >> i) & 16'h0001));
    end
    rd_reg(ADDR_CNT4, c);
    rd_chk(ADDR_GRA4, c);
    wr_reg(ADDR_IO_CH4, 16'h000c);
    wr_reg(ADDR_STAT0 + 5'h04, 16'h0000);
    lvl <= 1'b1;
    repeat (6) @(posedge clk);
    rd_chk(ADDR_STAT0 + 5'h04, 16'h00c0);
    pulse(6'h08);
    repeat (2) @(posedge clk);
    rd_chk(ADDR_STAT0 + 5'h04, 16'h00c1);
    give_verdict();
  end
endmodule

bind tcio_top tcio_assertions u_chk (.clk, .rst_n, .hw_stby, .addr, .wdata, .wr, .rd,
  .rdata, .ext_evt_a, .ch4_pin_a_out, .ch4_pin_a_oe_n, .match_irq_a, .overflow_irq,
  .adc_trigger);
`default_nettype wire
